// ===== logic/atsc_pkg.sv
`default_nettype none
package atsc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ATSC_CTRL_OFS = 4'h0;
  localparam logic [3:0] ATSC_TRIG_OFS = 4'h1;
  localparam logic [3:0] ATSC_DIDR_OFS = 4'h2;
  localparam logic [3:0] ATSC_STAT_OFS = 4'h3;
  localparam logic [3:0] ATSC_MASK_OFS = 4'h4;
  localparam logic [3:0] ATSC_RESL_OFS = 4'h5;
  localparam logic [3:0] ATSC_RESH_OFS = 4'h6;
  localparam logic [3:0] ATSC_PIN_OFS = 4'h7;
  localparam logic [3:0] ATSC_CHAN_OFS = 4'h8;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int ATSC_CTRL_EN_BIT = 0;
  localparam int ATSC_CTRL_START_BIT = 1;
  localparam int ATSC_CTRL_AUTO_BIT = 2;

  // ----------------------------------------
  // Status and mask bit positions
  // ----------------------------------------
  localparam int ATSC_ST_DONE_BIT = 0;
  localparam int ATSC_ST_SLEEP_BIT = 1;
  localparam int ATSC_ST_TRIG_BIT = 2;
  localparam int ATSC_ST_W = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ATSC_CTRL_RST = 8'h00;
  localparam logic [2:0] ATSC_TRIG_RST = 3'h0;
  localparam logic [5:0] ATSC_DIDR_RST = 6'h00;
  localparam logic [2:0] ATSC_MASK_RST = 3'h0;
  localparam logic [2:0] ATSC_CHAN_RST = 3'h0;

  // ----------------------------------------
  // Trigger source codes
  // ----------------------------------------
  localparam logic [2:0] ATSC_TS_FREE = 3'h0;
  localparam logic [2:0] ATSC_TS_CMP = 3'h1;
  localparam logic [2:0] ATSC_TS_EXT0 = 3'h2;
  localparam logic [2:0] ATSC_TS_T0CMPA = 3'h3;
  localparam logic [2:0] ATSC_TS_T0OVF = 3'h4;
  localparam logic [2:0] ATSC_TS_T1CMPB = 3'h5;
  localparam logic [2:0] ATSC_TS_T1OVF = 3'h6;
  localparam logic [2:0] ATSC_TS_T1CAP = 3'h7;

  // ----------------------------------------
  // Sleep mode codes
  // ----------------------------------------
  localparam logic [2:0] ATSC_SLP_IDLE = 3'h0;
  localparam logic [2:0] ATSC_SLP_NR = 3'h1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int ATSC_SYS_CLK_KHZ = 20000;
  localparam int ATSC_ADC_CLK_KHZ = 200;
  localparam int ATSC_ADC_DIV = ATSC_SYS_CLK_KHZ / ATSC_ADC_CLK_KHZ;
  localparam int ATSC_SAMPLE_ADC_CLKS = 3;
  localparam int ATSC_RES_W = 10;

  typedef enum logic [2:0] {
    ATSC_IDLE = 3'b001,
    ATSC_SAMPLE = 3'b010,
    ATSC_CONV = 3'b100
  } atsc_state_t;
endpackage
`default_nettype wire

// ===== logic/atsc_sar.sv
`default_nettype none
module atsc_sar
  import atsc_pkg::*;
#(
  parameter int DIV = ATSC_ADC_DIV,
  parameter int RES_W = ATSC_RES_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic start_i,
  input wire logic cmp_i,
  output logic busy_o,
  output logic done_o,
  output logic [RES_W-1:0] dac_o,
  output logic [RES_W-1:0] result_o
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);
  localparam logic [3:0] SMP_LAST = 4'(ATSC_SAMPLE_ADC_CLKS - 1);

  atsc_state_t state;
  logic [CW-1:0] cnt;
  logic [3:0] idx;
  logic tick;

  assign tick = (cnt == DIV_LAST);

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || state == ATSC_IDLE || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  // ----------------------------------------
  // Successive approximation sequence
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ATSC_IDLE;
      idx <= 4'h0;
      dac_o <= '0;
      result_o <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        ATSC_IDLE: begin
          if (en_i && start_i) begin
            state <= ATSC_SAMPLE;
            busy_o <= 1'b1;
            idx <= 4'h0;
            dac_o <= '0;
          end
        end
        ATSC_SAMPLE: begin
          if (!en_i) begin
            state <= ATSC_IDLE;
            busy_o <= 1'b0;
          end else if (tick) begin
            if (idx == SMP_LAST) begin
              state <= ATSC_CONV;
              idx <= 4'(RES_W - 1);
              dac_o <= RES_W'(1) << (RES_W - 1);
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        ATSC_CONV: begin
          if (!en_i) begin
            state <= ATSC_IDLE;
            busy_o <= 1'b0;
          end else if (tick) begin
            // Comparator high means input below trial code
            if (cmp_i) begin
              dac_o[idx] <= 1'b0;
            end
            if (idx == 4'h0) begin
              result_o <= cmp_i ? (dac_o & ~RES_W'(1)) : dac_o;
              state <= ATSC_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              dac_o[idx-4'h1] <= 1'b1;
              idx <= idx - 4'h1;
            end
          end
        end
        default: begin
          state <= ATSC_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== logic/atsc_top.sv
// Summary of operation
// - Halting in idle or noise-reduction sleep, converter enabled and idle, starts conversion.
// - Completion of sleep conversion raises done interrupt, waking the processor.
// - Done interrupt still raised when another interrupt woke the processor first.
// - After wake-up no new sleep conversion until another sleep entry.
// - Other sleep modes neither start nor switch off the converter.
// - Selected trigger source event starts conversion only while converter enabled.
// - Switching trigger selection to free running creates no trigger event.
// - Trigger codes: free, comparator, ext int 0, t0 cmpA, t0 ovf, t1 cmpB, ovf, capture.
// - Each of the six low input-disable bits turns off its pin input buffer.
// - A disabled channel's port input read bit always returns zero.
// - The two highest analog channels have no digital buffer, no disable bit.
`default_nettype none
module atsc_top
  import atsc_pkg::*;
#(
  parameter int NUM_DIG = 6,
  parameter int RES_W = ATSC_RES_W,
  parameter int DIV = ATSC_ADC_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic halt_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic [7:1] trig_src_i,
  input wire logic cmp_i,
  input wire logic [NUM_DIG-1:0] pin_i,
  output logic [NUM_DIG-1:0] din_buf_en_o,
  output logic [2:0] chan_o,
  output logic [RES_W-1:0] dac_o,
  output logic busy_o,
  output logic irq_o
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic converter_enable;
  logic auto_trig_en;
  logic [2:0] trigger_source_select;
  logic [NUM_DIG-1:0] channel_input_disable_bits;
  logic [ATSC_ST_W-1:0] status;
  logic [ATSC_ST_W-1:0] mask;
  logic [2:0] chan_sel;
  logic [RES_W-1:0] result;

  // ----------------------------------------
  // Synchronisers and edge state
  // ----------------------------------------
  logic [7:1] trig_s1;
  logic [7:1] trig_s2;
  logic cmp_s1;
  logic cmp_s2;
  logic [NUM_DIG-1:0] pin_s1;
  logic [NUM_DIG-1:0] pin_s2;
  logic [2:0] sel_q;
  logic src_q;
  logic halt_q;

  // ----------------------------------------
  // Combinational
  // ----------------------------------------
  logic src_now;
  logic trig_evt;
  logic sleep_evt;
  logic sw_start;
  logic start;
  logic sar_busy;
  logic sar_done;
  logic [RES_W-1:0] sar_result;
  logic [RES_W-1:0] sar_dac;
  logic [ATSC_ST_W-1:0] st_set;
  logic [ATSC_ST_W-1:0] st_clr;
  logic [7:0] next_rdata;
  logic [NUM_DIG-1:0] pin_view;
  logic ctrl_wr;
  logic next_en;

  assign ctrl_wr = wr_i && addr_i == ATSC_CTRL_OFS;
  assign sw_start = ctrl_wr && wdata_i[ATSC_CTRL_START_BIT];

  // ----------------------------------------
  // Trigger source decode
  // ----------------------------------------
  always_comb begin
    case (trigger_source_select)
      ATSC_TS_FREE: src_now = status[ATSC_ST_DONE_BIT];
      ATSC_TS_CMP: src_now = trig_s2[1];
      ATSC_TS_EXT0: src_now = trig_s2[2];
      ATSC_TS_T0CMPA: src_now = trig_s2[3];
      ATSC_TS_T0OVF: src_now = trig_s2[4];
      ATSC_TS_T1CMPB: src_now = trig_s2[5];
      ATSC_TS_T1OVF: src_now = trig_s2[6];
      ATSC_TS_T1CAP: src_now = trig_s2[7];
      default: src_now = 1'b0;
    endcase
  end

  // Edge only counts when the selection is unchanged since last cycle
  assign trig_evt = auto_trig_en && src_now && !src_q && sel_q == trigger_source_select;

  // New halt only; a wake then re-halt is needed for another run
  assign sleep_evt = halt_i && !halt_q
    && (sleep_mode_i == ATSC_SLP_IDLE || sleep_mode_i == ATSC_SLP_NR);

  // ----------------------------------------
  // Start request
  // ----------------------------------------
  // Enable written beside start counts in that same cycle
  // Otherwise a first write of enable and start together would be lost
  assign next_en = ctrl_wr ? wdata_i[ATSC_CTRL_EN_BIT] : converter_enable;

  // Busy or disabled converter ignores every start source
  assign start = next_en && !sar_busy && (sw_start || trig_evt || sleep_evt);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      cmp_s1 <= cmp_i;
      cmp_s2 <= cmp_s1;
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
    end
  end

  // One two-stage synchroniser per trigger source
  // Sources run off other logic; nothing reads the first stage
  for (genvar s = 1; s < 8; s++) begin : g_src
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        trig_s1[s] <= 1'b0;
        trig_s2[s] <= 1'b0;
      end else begin
        trig_s1[s] <= trig_src_i[s];
        trig_s2[s] <= trig_s1[s];
      end
    end
  end

  // ----------------------------------------
  // Edge detection state
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= ATSC_TRIG_RST;
      src_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      sel_q <= trigger_source_select;
      src_q <= src_now;
      halt_q <= halt_i;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_enable <= ATSC_CTRL_RST[ATSC_CTRL_EN_BIT];
      auto_trig_en <= ATSC_CTRL_RST[ATSC_CTRL_AUTO_BIT];
    end else if (ctrl_wr) begin
      // Sleep entry leaves enable alone; software owns power-down
      converter_enable <= wdata_i[ATSC_CTRL_EN_BIT];
      auto_trig_en <= wdata_i[ATSC_CTRL_AUTO_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_source_select <= ATSC_TRIG_RST;
    end else if (wr_i && addr_i == ATSC_TRIG_OFS) begin
      trigger_source_select <= wdata_i[2:0];
    end
  end

  // Upper bits dropped; software keeps them zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_input_disable_bits <= ATSC_DIDR_RST;
    end else if (wr_i && addr_i == ATSC_DIDR_OFS) begin
      channel_input_disable_bits <= wdata_i[NUM_DIG-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= ATSC_MASK_RST;
    end else if (wr_i && addr_i == ATSC_MASK_OFS) begin
      mask <= wdata_i[ATSC_ST_W-1:0];
    end
  end

  // Channel change mid-conversion is software's hazard to avoid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_sel <= ATSC_CHAN_RST;
    end else if (wr_i && addr_i == ATSC_CHAN_OFS) begin
      chan_sel <= wdata_i[2:0];
    end
  end

  // ----------------------------------------
  // Converter sequencer
  // ----------------------------------------
  atsc_sar #(
    .DIV(DIV),
    .RES_W(RES_W)
  ) u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(next_en),
    .start_i(start),
    .cmp_i(cmp_s2),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .dac_o(sar_dac),
    .result_o(sar_result)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (sar_done) begin
      result <= sar_result;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Done is flagged whatever woke the processor meanwhile
  always_comb begin
    st_set = '0;
    st_set[ATSC_ST_DONE_BIT] = sar_done;
    st_set[ATSC_ST_SLEEP_BIT] = start && sleep_evt;
    st_set[ATSC_ST_TRIG_BIT] = start && trig_evt;
  end

  assign st_clr = (wr_i && addr_i == ATSC_STAT_OFS) ? wdata_i[ATSC_ST_W-1:0] : '0;

  // Set beats clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // ----------------------------------------
  // Pin buffers and reads
  // ----------------------------------------
  // One slice per channel that owns a digital buffer
  for (genvar ch = 0; ch < NUM_DIG; ch++) begin : g_chan
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        din_buf_en_o[ch] <= 1'b1;
      end else begin
        din_buf_en_o[ch] <= !channel_input_disable_bits[ch];
      end
    end

    // Disabled channel reads zero whatever the pad shows
    assign pin_view[ch] = pin_s2[ch] && !channel_input_disable_bits[ch];
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_o <= ATSC_CHAN_RST;
      dac_o <= '0;
      busy_o <= 1'b0;
    end else begin
      chan_o <= chan_sel;
      dac_o <= sar_dac;
      busy_o <= sar_busy;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (addr_i == ATSC_CTRL_OFS) begin
      next_rdata[ATSC_CTRL_EN_BIT] = converter_enable;
      next_rdata[ATSC_CTRL_START_BIT] = sar_busy;
      next_rdata[ATSC_CTRL_AUTO_BIT] = auto_trig_en;
    end else if (addr_i == ATSC_TRIG_OFS) begin
      next_rdata[2:0] = trigger_source_select;
    end else if (addr_i == ATSC_DIDR_OFS) begin
      next_rdata[NUM_DIG-1:0] = channel_input_disable_bits;
    end else if (addr_i == ATSC_STAT_OFS) begin
      next_rdata[ATSC_ST_W-1:0] = status;
    end else if (addr_i == ATSC_MASK_OFS) begin
      next_rdata[ATSC_ST_W-1:0] = mask;
    end else if (addr_i == ATSC_RESL_OFS) begin
      next_rdata = result[7:0];
    end else if (addr_i == ATSC_RESH_OFS) begin
      next_rdata[RES_W-9:0] = result[RES_W-1:8];
    end else if (addr_i == ATSC_PIN_OFS) begin
      next_rdata[NUM_DIG-1:0] = pin_view;
    end else if (addr_i == ATSC_CHAN_OFS) begin
      next_rdata[2:0] = chan_sel;
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== sim/atsc_host_model.sv
`default_nettype none
module atsc_host_model
  import atsc_pkg::*;
#(
  parameter logic [ATSC_RES_W-1:0] AVAL = 10'h2b6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] mode_i,
  input wire logic wake_i,
  input wire logic irq_i,
  input wire logic [ATSC_RES_W-1:0] dac_i,
  output logic halt_o,
  output logic [2:0] sleep_mode_o,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // High while the held input lies below the trial code
  assign cmp_o = AVAL < dac_i;
  // Core stays awake after a wake-up until the next sleep request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_o <= 1'b0;
      sleep_mode_o <= ATSC_SLP_IDLE;
    end else if (sleep_req_i) begin
      halt_o <= 1'b1;
      sleep_mode_o <= mode_i;
    end else if (irq_i || wake_i) begin
      halt_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/atsc_top_sva.sv
`default_nettype none
module atsc_top_sva
  import atsc_pkg::*;
#(
  parameter int NUM_DIG = 6,
  parameter int RES_W = ATSC_RES_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic halt_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic [7:1] trig_src_i,
  input wire logic cmp_i,
  input wire logic [NUM_DIG-1:0] pin_i,
  input wire logic [NUM_DIG-1:0] din_buf_en_o,
  input wire logic [2:0] chan_o,
  input wire logic [RES_W-1:0] dac_o,
  input wire logic busy_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // Shadow of software-written fields
  // --------------------------------
  logic en_q;
  logic auto_q;
  logic [2:0] ts_q;
  logic [2:0] mask_q;
  logic [NUM_DIG-1:0] dis_q;
  logic sel;
  // Code 0 is out of range of the source vector; the guard keeps sel at 0
  assign sel = (ts_q != 3'h0) && trig_src_i[ts_q];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      auto_q <= 1'b0;
      ts_q <= ATSC_TRIG_RST;
      mask_q <= ATSC_MASK_RST;
      dis_q <= ATSC_DIDR_RST;
    end else if (wr_i) begin
      if (addr_i == ATSC_CTRL_OFS) begin
        en_q <= wdata_i[ATSC_CTRL_EN_BIT];
        auto_q <= wdata_i[ATSC_CTRL_AUTO_BIT];
      end
      if (addr_i == ATSC_TRIG_OFS) ts_q <= wdata_i[2:0];
      if (addr_i == ATSC_MASK_OFS) mask_q <= wdata_i[2:0];
      if (addr_i == ATSC_DIDR_OFS) dis_q <= wdata_i[NUM_DIG-1:0];
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_sleep_entry;
    $rose(halt_i) && sleep_mode_i <= ATSC_SLP_NR && en_q && !busy_o;
  endsequence
  sequence s_conv_end;
    $fell(busy_o) && en_q;
  endsequence
  sequence s_trig_edge;
    $rose(sel) && $stable(ts_q) && en_q && auto_q && !busy_o;
  endsequence
  property p_sleep_start;
    s_sleep_entry |-> ##[1:3] busy_o;
  endproperty
  property p_done_irq;
    s_conv_end ##0 mask_q[ATSC_ST_DONE_BIT] |-> ##[1:3] irq_o;
  endproperty
  property p_irq_masked;
    (mask_q == 3'h0) [*2] |-> !irq_o;
  endproperty
  property p_dis_quiet;
    !en_q [*3] |-> !busy_o;
  endproperty
  property p_free_quiet;
    wr_i && addr_i == ATSC_TRIG_OFS && wdata_i[2:0] == ATSC_TS_FREE && !busy_o && !halt_i |=> !busy_o [*4];
  endproperty
  property p_other_sleep;
    $rose(halt_i) && sleep_mode_i > ATSC_SLP_NR && busy_o |=> busy_o;
  endproperty
  property p_buf_off;
    $past(dis_q, 2) == dis_q |-> din_buf_en_o == ~dis_q;
  endproperty
  property p_trig_start;
    s_trig_edge |-> ##[2:7] busy_o;
  endproperty
  a_sleep_start: assert property (p_sleep_start)
    else $error("sleep entry started no conversion");
  a_done_irq: assert property (p_done_irq)
    else $error("completion raised no interrupt");
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with all masks clear");
  a_dis_quiet: assert property (p_dis_quiet)
    else $error("busy while converter disabled");
  a_free_quiet: assert property (p_free_quiet)
    else $error("free running selection started a conversion");
  a_other_sleep: assert property (p_other_sleep)
    else $error("other sleep mode stopped the conversion");
  a_buf_off: assert property (p_buf_off)
    else $error("input buffer enables disagree with disable bits");
  a_trig_start: assert property (p_trig_start)
    else $error("trigger edge started no conversion");
endmodule
bind atsc_top atsc_top_sva #(
  .NUM_DIG(NUM_DIG),
  .RES_W(RES_W)
) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .halt_i(halt_i), .sleep_mode_i(sleep_mode_i), .trig_src_i(trig_src_i),
  .cmp_i(cmp_i), .pin_i(pin_i), .din_buf_en_o(din_buf_en_o), .chan_o(chan_o), .dac_o(dac_o),
  .busy_o(busy_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== sim/tb_atsc_top.sv
`default_nettype none
module tb_atsc_top
  import atsc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // Short divider keeps each conversion at 52 cycles
  localparam int DIV = 4;
  localparam logic [9:0] AVAL = 10'h2b6;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } atsc_row_t;
  logic clk_i, rst_i, wr_i, rd_i, halt_i, cmp_i, busy_o, irq_o, sleep_req, wake;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [2:0] sleep_mode_i, chan_o, mode;
  logic [7:1] trig_src_i;
  logic [5:0] pin_i, din_buf_en_o, dd;
  logic [9:0] dac_o;
  int miscompares;
  int check_count;
  atsc_row_t rows [10] = '{'{ATSC_DIDR_OFS, 8'h3f, 8'h3f}, '{ATSC_TRIG_OFS, 8'h07, 8'h07},
    '{ATSC_CHAN_OFS, 8'h07, 8'h07}, '{ATSC_MASK_OFS, 8'h07, 8'h07}, '{ATSC_DIDR_OFS, 8'h2a, 8'h2a},
    '{4'hf, 8'h5a, 8'h00}, '{ATSC_MASK_OFS, 8'h00, 8'h00}, '{ATSC_DIDR_OFS, 8'h00, 8'h00},
    '{ATSC_TRIG_OFS, 8'h00, 8'h00}, '{ATSC_CHAN_OFS, 8'h03, 8'h03}};
  atsc_top #(.DIV(DIV)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .halt_i(halt_i), .sleep_mode_i(sleep_mode_i), .trig_src_i(trig_src_i),
    .cmp_i(cmp_i), .pin_i(pin_i), .din_buf_en_o(din_buf_en_o), .chan_o(chan_o), .dac_o(dac_o),
    .busy_o(busy_o), .irq_o(irq_o)
  );
  atsc_host_model #(.AVAL(AVAL)) u_host (
    .clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req), .mode_i(mode), .wake_i(wake),
    .irq_i(irq_o), .dac_i(dac_o), .halt_o(halt_i), .sleep_mode_o(sleep_mode_i), .cmp_o(cmp_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // --------------------------------
  // Bus and check helpers
  // --------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string msg);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, msg);
  endtask
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({7'h0, busy_o}, {7'h0, v}, "busy");
  endtask
  task automatic quiet(input int n);
    logic b;
    b = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      b = b | busy_o;
    end
    chk({7'h0, b}, 8'h00, "spurious start");
  endtask
  task automatic conv(input logic [7:0] st);
    wt(1'b1);
    wt(1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    chk({7'h0, irq_o}, 8'h01, "irq set");
    rc(ATSC_STAT_OFS, st, "status");
    wr(ATSC_STAT_OFS, 8'h07);
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h0, irq_o}, 8'h00, "irq clear");
  endtask
  task automatic slp(input logic [2:0] m);
    @(posedge clk_i);
    sleep_req <= 1'b1;
    mode <= m;
    @(posedge clk_i);
    sleep_req <= 1'b0;
  endtask
  task automatic tp(input int c);
    @(posedge clk_i);
    trig_src_i[c] <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_src_i <= 7'h00;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    finish_test;
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {rst_i, addr_i, wdata_i, wr_i, rd_i, trig_src_i, sleep_req, mode, wake, dd} = {1'h1, 32'h00000000};
    pin_i = 6'h3c;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({2'h0, din_buf_en_o}, 8'h3f, "buffer reset");
    for (int a = 0; a < 5; a++) rc(a[3:0], 8'h00, "reset value");
    $display("end of test: reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == ATSC_DIDR_OFS) dd = rows[i].d[5:0];
      rc(rows[i].a, rows[i].e, "register");
      rc(ATSC_PIN_OFS, {2'h0, pin_i & ~dd}, "pin");
      chk({2'h0, din_buf_en_o}, {2'h0, ~dd}, "buffer");
    end
    $display("end of test: registers");
    wr(ATSC_CHAN_OFS, 8'h06);
    wr(ATSC_MASK_OFS, 8'h01);
    wr(ATSC_CTRL_OFS, 8'h03);
    chk({5'h0, chan_o}, 8'h06, "channel");
    conv(8'h01);
    rc(ATSC_RESL_OFS, AVAL[7:0], "result low");
    rc(ATSC_RESH_OFS, {6'h0, AVAL[9:8]}, "result high");
    wr(ATSC_CTRL_OFS, 8'h01);
    slp(ATSC_SLP_NR);
    conv(8'h03);
    chk({7'h0, halt_i}, 8'h00, "woken");
    quiet(40);
    slp(ATSC_SLP_IDLE);
    wt(1'b1);
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    conv(8'h03);
    quiet(40);
    $display("end of test: sleep");
    slp(3'h2);
    quiet(20);
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    wr(ATSC_CTRL_OFS, 8'h03);
    wt(1'b1);
    slp(3'h3);
    conv(8'h01);
    $display("end of test: other sleep");
    wr(ATSC_CTRL_OFS, 8'h00);
    wr(ATSC_TRIG_OFS, 8'h01);
    wr(ATSC_CTRL_OFS, 8'h04);
    tp(1);
    quiet(20);
    wr(ATSC_CTRL_OFS, 8'h02);
    quiet(10);
    wr(ATSC_CTRL_OFS, 8'h03);
    wt(1'b1);
    wr(ATSC_CTRL_OFS, 8'h00);
    wt(1'b0);
    repeat (4) @(posedge clk_i);
    rc(ATSC_STAT_OFS, 8'h00, "abort status");
    $display("end of test: enable");
    wr(ATSC_CTRL_OFS, 8'h05);
    for (int c = 1; c < 8; c++) begin
      wr(ATSC_TRIG_OFS, c[7:0]);
      tp((c % 7) + 1);
      quiet(10);
      tp(c);
      conv(8'h05);
    end
    $display("end of test: trigger sources");
    wr(ATSC_MASK_OFS, 8'h00);
    wr(ATSC_CTRL_OFS, 8'h07);
    wt(1'b1);
    wt(1'b0);
    wr(ATSC_TRIG_OFS, 8'h00);
    quiet(20);
    chk({7'h0, irq_o}, 8'h00, "masked irq");
    rc(ATSC_STAT_OFS, 8'h01, "done kept");
    $display("end of test: free running switch");
    finish_test;
  end
endmodule
`default_nettype wire
